/* File: sfm_flag_mask.v */
`timescale 1ns/1ps
`include "sfm_defines.vh"
module sfm_flag_mask (
  input wire hclk, // System clock
  input wire hresetn, // Async reset, active low
  input wire hsel, // AHB slave select
  input wire [31:0] haddr, // AHB address
  input wire [1:0] htrans, // AHB transfer type
  input wire hwrite, // AHB write
  input wire [2:0] hsize, // AHB size
  input wire [31:0] hwdata, // AHB write data
  input wire hready, // AHB bus ready
  output reg [31:0] hrdata, // AHB read data
  output wire hreadyout, // AHB slave ready
  output wire hresp, // AHB response
  input wire supply_ov_pin, // Supply overvoltage comparator
  input wire mirror_fb_low_pin, // Feedback below target comparator
  input wire mirror_fb_high_pin, // Feedback above target comparator
  input wire [11:0] underload_pin, // Per-output underload, bit0 high1, bit1 low1
  input wire thermal_warn_pin, // Thermal warning comparator
  input wire other_error, // Other global error sources
  output reg outputs_enable, // Output stages allowed on
  output reg mirror_below_target, // Filtered below-target
  output reg mirror_above_target, // Filtered above-target
  output reg global_underload, // Global underload flag
  output reg thermal_warning_flag, // Global thermal warning
  output reg global_error, // Global error flag
  output reg mirror_pwm_discharge, // Mirror low-side discharge active
  output reg mirror_oc_recovery_eff, // Effective overcurrent recovery
  output wire irq // Interrupt, active high level
);

  // Two-flop synchronisers for analog inputs
  reg [15:0] sync1_reg;
  reg [15:0] sync2_reg;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 16'h0000;
      sync2_reg <= 16'h0000;
    end else begin
      sync1_reg <= {thermal_warn_pin, mirror_fb_high_pin, mirror_fb_low_pin,
                    supply_ov_pin, underload_pin};
      sync2_reg <= sync1_reg;
    end
  end
  wire [11:0] uld_s = sync2_reg[11:0];
  wire ov_s = sync2_reg[12];
  wire fb_lo_s = sync2_reg[13];
  wire fb_hi_s = sync2_reg[14];
  wire tw_s = sync2_reg[15];

  // Address match on the low twelve bits of a byte address
  function sfm_hit;
    input [11:0] addr;
    input [11:0] target;
    begin
      sfm_hit = (addr == target);
    end
  endfunction

  // Masked underload reduction shared by flag, error and event paths;
  // the global mask wins over the per-output masks
  function sfm_uld_any;
    input [11:0] uld;
    input [15:0] cfg;
    reg [11:0] keep;
    begin
      keep = uld & {10'h3ff, ~cfg[`SFM_CFG_ULD_LOW1],
                    ~cfg[`SFM_CFG_ULD_HIGH1]};
      sfm_uld_any = (|keep) & ~cfg[`SFM_CFG_ULD_ALL];
    end
  endfunction

  // AHB address phase capture
  reg wr_pend_reg;
  reg rd_pend_reg;
  reg [11:0] addr_reg;
  wire xfer = hsel & htrans[1] & hready;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 12'h000;
    end else begin
      wr_pend_reg <= xfer & hwrite;
      rd_pend_reg <= xfer & ~hwrite;
      if (xfer)
        addr_reg <= haddr[11:0];
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Write strobes in the data phase, when hwdata stands
  wire wr_cfg = wr_pend_reg & sfm_hit(addr_reg, `SFM_ADDR_CONFIG);
  wire wr_evt = wr_pend_reg & sfm_hit(addr_reg, `SFM_ADDR_EVENT);
  wire wr_msk = wr_pend_reg & sfm_hit(addr_reg, `SFM_ADDR_MASK);
  wire wr_ctl = wr_pend_reg & sfm_hit(addr_reg, `SFM_ADDR_CONTROL);

  // Configuration register, unused bits forced to zero
  reg [15:0] cfg_reg;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cfg_reg <= `SFM_CFG_RESET;
    else if (wr_cfg)
      cfg_reg <= hwdata[15:0] & `SFM_CFG_WMASK;
  end

  // Control register: latch select and mirror recovery request
  reg [31:0] ctl_reg;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      ctl_reg <= `SFM_CTL_RESET;
    else if (wr_ctl)
      ctl_reg <= hwdata & `SFM_CTL_WMASK;
  end

  // Interrupt mask, same layout as the event register
  reg [`SFM_EV_W-1:0] mask_reg;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      mask_reg <= `SFM_MASK_RESET;
    else if (wr_msk)
      mask_reg <= hwdata[`SFM_EV_W-1:0];
  end
  wire latch_sel = ctl_reg[`SFM_CTL_LATCH_SEL];
  wire oc_rec = ctl_reg[`SFM_CTL_OC_REC];

  // Overvoltage flag: set wins over host clear
  reg ov_flag_reg;
  wire ov_clr = wr_evt & hwdata[`SFM_EV_OV];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ov_flag_reg <= 1'b0;
    end else if (ov_s) begin
      ov_flag_reg <= 1'b1;
    end else if (!latch_sel) begin
      ov_flag_reg <= 1'b0;
    end else if (ov_clr) begin
      ov_flag_reg <= 1'b0;
    end
  end

  // Outputs off immediately on overvoltage, held while flag set
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      outputs_enable <= 1'b0;
    else
      outputs_enable <= ~ov_s & ~ov_flag_reg;
  end

  // Mirror comparison persistence filter
  reg [1:0] cand_reg;
  reg [`SFM_CNT_W-1:0] cnt_reg;
  wire [1:0] cmp_now = fb_lo_s & fb_hi_s ? 2'b00 : {fb_lo_s, fb_hi_s};
  // Count saturates at the end of the window, so the indication
  // can never move faster than once per persistence window
  wire settled = (cmp_now == cand_reg) &&
                 (cnt_reg == `SFM_SETTLE_CYC - 1);

  // Candidate comparison and its persistence count
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cand_reg <= 2'b00;
      cnt_reg <= {`SFM_CNT_W{1'b0}};
    end else if (cmp_now != cand_reg) begin
      cand_reg <= cmp_now;
      cnt_reg <= {`SFM_CNT_W{1'b0}};
    end else if (!settled) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Indication moves only once the candidate has persisted
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mirror_below_target <= 1'b0;
      mirror_above_target <= 1'b0;
    end else if (settled) begin
      mirror_below_target <= cand_reg[1];
      mirror_above_target <= cand_reg[0];
    end
  end

  // Global underload after the per-output and global masks
  wire uld_global = sfm_uld_any(uld_s, cfg_reg);
  // Thermal warning after its mask
  wire tw_global = tw_s & ~cfg_reg[`SFM_CFG_TW];

  // Global underload flag
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      global_underload <= 1'b0;
    else
      global_underload <= uld_global;
  end

  // Global thermal warning flag
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      thermal_warning_flag <= 1'b0;
    else
      thermal_warning_flag <= tw_global;
  end

  // Global error; mirror status bits deliberately left out
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      global_error <= 1'b0;
    else
      global_error <= ov_flag_reg | other_error | uld_global;
  end

  // Mirror discharge follows its enable bit
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      mirror_pwm_discharge <= 1'b0;
    else
      mirror_pwm_discharge <= cfg_reg[`SFM_CFG_PWM_DIS];
  end

  // Discharge overrides whatever recovery the host asked for
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      mirror_oc_recovery_eff <= 1'b0;
    else
      mirror_oc_recovery_eff <= oc_rec &
                                ~cfg_reg[`SFM_CFG_PWM_DIS];
  end

  // Sticky event bits, set wins over write-one clear
  reg [`SFM_EV_W-1:0] evt_reg;
  reg [1:0] mir_prev_reg;
  wire [`SFM_EV_W-1:0] evt_set = {
    {mir_prev_reg != {mirror_below_target, mirror_above_target}},
    tw_global,
    uld_global,
    ov_s};
  wire [`SFM_EV_W-1:0] evt_clr = wr_evt ? hwdata[`SFM_EV_W-1:0] : 4'h0;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_reg <= 4'h0;
      mir_prev_reg <= 2'b00;
    end else begin
      evt_reg <= (evt_reg & ~evt_clr) | evt_set;
      mir_prev_reg <= {mirror_below_target, mirror_above_target};
    end
  end
  assign irq = |(evt_reg & mask_reg);

  // Read mux, unmapped reads zero
  wire [31:0] status_word = {26'h0000000, global_error, thermal_warning_flag,
                             global_underload, ov_flag_reg,
                             mirror_below_target, mirror_above_target};
  // Read selection on the address phase, unmapped addresses read zero
  reg [31:0] rd_mux;
  always @* begin
    if (sfm_hit(haddr[11:0], `SFM_ADDR_CONFIG))
      rd_mux = {16'h0000, cfg_reg};
    else if (sfm_hit(haddr[11:0], `SFM_ADDR_STATUS))
      rd_mux = status_word;
    else if (sfm_hit(haddr[11:0], `SFM_ADDR_EVENT))
      rd_mux = {28'h0000000, evt_reg};
    else if (sfm_hit(haddr[11:0], `SFM_ADDR_MASK))
      rd_mux = {28'h0000000, mask_reg};
    else if (sfm_hit(haddr[11:0], `SFM_ADDR_CONTROL))
      rd_mux = ctl_reg;
    else
      rd_mux = 32'h00000000;
  end

  // Read data registered at the address phase edge; it stands through
  // the data phase and until the next read
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (xfer & ~hwrite)
      hrdata <= rd_mux;
  end

endmodule // sfm_flag_mask

/* File: sfm_defines.vh */
`ifndef SFM_DEFINES_VH
`define SFM_DEFINES_VH
// Register indices; byte address is four times the index
`define SFM_IDX_CONFIG 8'h3f
`define SFM_IDX_STATUS 8'h40
`define SFM_IDX_EVENT 8'h41
`define SFM_IDX_MASK 8'h42
`define SFM_IDX_CONTROL 8'h43
`define SFM_ADDR_CONFIG 12'h0fc
`define SFM_ADDR_STATUS 12'h100
`define SFM_ADDR_EVENT 12'h104
`define SFM_ADDR_MASK 12'h108
`define SFM_ADDR_CONTROL 12'h10c
// Configuration field positions
`define SFM_CFG_ULD_ALL 1
`define SFM_CFG_TW 3
`define SFM_CFG_ULD_LOW1 4
`define SFM_CFG_ULD_HIGH1 5
`define SFM_CFG_PWM_DIS 7
`define SFM_CFG_WMASK 16'h00ba
`define SFM_CFG_RESET 16'h0000
// Control field positions
`define SFM_CTL_LATCH_SEL 0
`define SFM_CTL_OC_REC 1
`define SFM_CTL_WMASK 32'h00000003
`define SFM_CTL_RESET 32'h00000000
`define SFM_MASK_RESET 4'h0
// Status field positions
`define SFM_ST_ABOVE 0
`define SFM_ST_BELOW 1
`define SFM_ST_OV 2
`define SFM_ST_ULD 3
`define SFM_ST_TW 4
`define SFM_ST_ERR 5
// Event bits
`define SFM_EV_OV 0
`define SFM_EV_ULD 1
`define SFM_EV_TW 2
`define SFM_EV_MIRROR 3
`define SFM_EV_W 4
// Timing
`define SFM_CLK_MHZ 50
`define SFM_SETTLE_US 32
`define SFM_SETTLE_CYC (`SFM_SETTLE_US * `SFM_CLK_MHZ)
`define SFM_CNT_W 11
`endif

/* File: sfm_flag_mask_properties.sv */
`timescale 1ns/1ps
module sfm_props (
  input wire hclk, // Clock
  input wire hresetn, // Reset, active low
  input wire supply_ov_pin, // Overvoltage in
  input wire [11:0] underload_pin, // Underload in
  input wire thermal_warn_pin, // Warning in
  input wire other_error, // Other errors
  input wire outputs_enable, // Outputs allowed
  input wire mirror_below_target, // Below
  input wire mirror_above_target, // Above
  input wire global_underload, // Underload flag
  input wire thermal_warning_flag, // Warning flag
  input wire global_error, // Error flag
  input wire mirror_pwm_discharge, // Discharge on
  input wire mirror_oc_recovery_eff // Recovery on
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  reg [10:0] hold_cnt; // Cycles since the mirror pair moved
  // Count how long the mirror pair has held still
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hold_cnt <= 11'h0;
    else if ($changed({mirror_below_target, mirror_above_target}))
      hold_cnt <= 11'h0;
    else if (hold_cnt != 11'h7ff)
      hold_cnt <= hold_cnt + 11'h1;
  end
  ov_shutoff_a: assert property (
    $rose(supply_ov_pin) |-> ##[2:5] !outputs_enable) else $error("no off");
  mirror_pair_a: assert property (
    !(mirror_below_target && mirror_above_target)) else $error("pair 11");
  settle_hold_a: assert property (
    $changed({mirror_below_target, mirror_above_target}) |->
    hold_cnt >= 11'h63f) else $error("mirror too fast");
  pwm_recovery_a: assert property (
    mirror_pwm_discharge |-> !mirror_oc_recovery_eff) else $error("recov");
  warn_cause_a: assert property (
    $rose(thermal_warning_flag) |-> $past(thermal_warn_pin, 3))
    else $error("warn cause");
  uld_cause_a: assert property (
    $rose(global_underload) |-> $past(underload_pin, 3) != 12'h0)
    else $error("uld cause");
  err_cause_a: assert property (
    $rose(global_error) |-> $past(other_error) || global_underload ||
    supply_ov_pin) else $error("error cause");
  err_quiet_a: assert property (
    $rose(mirror_below_target) && !other_error && !global_underload &&
    outputs_enable |=> !global_error) else $error("mirror error");
endmodule // sfm_props
bind sfm_flag_mask sfm_props u_props (.*);

/* File: sfm_host.sv */
`timescale 1ns/1ps
module sfm_host (
  input wire hclk, // Clock
  input wire [31:0] hrdata, // Read data
  input wire hreadyout, // Slave ready
  output reg hsel, // Select
  output reg [31:0] haddr, // Address
  output reg [1:0] htrans, // Transfer type
  output reg hwrite, // Write
  output reg [31:0] hwdata // Write data
);
  initial {hsel, haddr, htrans, hwrite, hwdata} = 68'h0;
  // One single word transfer, holding each phase until ready
  task xfer(input w, input [31:0] a, d, output [31:0] q);
    begin
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      q = hrdata;
    end
  endtask
endmodule // sfm_host

/* File: sfm_flag_mask_test.sv */
`timescale 1ns/1ps
`include "sfm_defines.vh"
module sfm_flag_mask_test;
  reg hclk, hresetn, supply_ov_pin, mirror_fb_low_pin, mirror_fb_high_pin;
  reg thermal_warn_pin, other_error;
  reg [11:0] underload_pin;
  wire [31:0] haddr, hwdata, hrdata;
  wire [1:0] htrans;
  wire [2:0] hsize = 3'h2;
  wire hsel, hwrite, hreadyout, hresp, outputs_enable, mirror_below_target;
  wire mirror_above_target, global_underload, thermal_warning_flag, irq;
  wire global_error, mirror_pwm_discharge, mirror_oc_recovery_eff;
  wire hready = hreadyout;
  wire [1:0] mp = {mirror_below_target, mirror_above_target};
  wire [3:0] fl = {global_underload, thermal_warning_flag,
    mirror_pwm_discharge, mirror_oc_recovery_eff};
  integer miscompares = 0, n_compared = 0, cyc = 0, i;
  reg [31:0] q;
  reg [27:0] tab [0:5];
  sfm_host u_host (.*);
  sfm_flag_mask DUT (.*);
  // Clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      stop_test;
    end
  end
  task chk(input [31:0] got, exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [31:0] a, d);
    u_host.xfer(1'b1, a, d, q);
  endtask
  task rd(input [31:0] a);
    u_host.xfer(1'b0, a, 32'h0, q);
  endtask
  task tick(input integer n);
    repeat (n) @(posedge hclk);
  endtask
  task stop_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Only bits 1,3,4,5,7 hold; unmapped reads zero
  task t_cfg;
    begin
      rd(`SFM_ADDR_CONFIG);
      chk(q, 32'h0);
      wr(`SFM_ADDR_CONFIG, 32'hffffffff);
      rd(`SFM_ADDR_CONFIG);
      chk(q, 32'hba);
      hresetn <= 1'b0;
      tick(2);
      hresetn <= 1'b1;
      tick(1);
      rd(`SFM_ADDR_CONFIG);
      chk(q, 32'h0);
      chk({hreadyout, hresp}, 2'b10);
      wr(`SFM_ADDR_CONFIG, 32'hffffffff);
      rd(32'h200);
      chk(q, 32'h0);
      $display("config done");
    end
  endtask
  // Overvoltage in auto and latched recovery, with interrupt
  task t_ov;
    begin
      wr(`SFM_ADDR_MASK, 32'h1);
      supply_ov_pin <= 1'b1;
      tick(8);
      chk({outputs_enable, irq}, 2'b01);
      rd(`SFM_ADDR_STATUS);
      chk(q[2], 1'b1);
      supply_ov_pin <= 1'b0;
      tick(8);
      chk(outputs_enable, 1'b1);
      wr(`SFM_ADDR_EVENT, 32'h1);
      wr(`SFM_ADDR_CONTROL, 32'h1);
      chk(irq, 1'b0);
      supply_ov_pin <= 1'b1;
      tick(8);
      supply_ov_pin <= 1'b0;
      tick(8);
      chk(outputs_enable, 1'b0);
      wr(`SFM_ADDR_EVENT, 32'h1);
      tick(3);
      chk({outputs_enable, irq}, 2'b10);
      $display("overvoltage done");
    end
  endtask
  // Mask table: pins, warning pin, config, expected flags
  task t_flags;
    begin
      wr(`SFM_ADDR_CONTROL, 32'h2);
      for (i = 0; i < 6; i = i + 1) begin
        wr(`SFM_ADDR_CONFIG, {24'h0, tab[i][11:4]});
        underload_pin <= tab[i][27:16];
        thermal_warn_pin <= tab[i][12];
        tick(8);
        chk(fl, tab[i][3:0]);
      end
      underload_pin <= 12'h0;
      thermal_warn_pin <= 1'b0;
      $display("flags done");
    end
  endtask
  // Mirror indication only after 32 us of steady deviation
  task t_mirror;
    begin
      mirror_fb_low_pin <= 1'b1;
      tick(1500);
      chk(mp, 2'b00);
      tick(200);
      chk({mp, global_error}, 3'b100);
      rd(`SFM_ADDR_STATUS);
      chk(q[1:0], 2'b10);
      rd(`SFM_ADDR_EVENT);
      chk(q, 32'he);
      mirror_fb_low_pin <= 1'b0;
      mirror_fb_high_pin <= 1'b1;
      tick(1700);
      chk(mp, 2'b01);
      mirror_fb_low_pin <= 1'b1;
      tick(1700);
      chk(mp, 2'b00);
      $display("mirror done");
    end
  endtask
  // Reset, then the scenarios in turn
  initial begin
    {hresetn, supply_ov_pin, mirror_fb_low_pin, mirror_fb_high_pin} = 4'h0;
    {thermal_warn_pin, other_error, underload_pin} = 14'h0;
    tab[0] = 28'h0010009;
    tab[1] = 28'h0011205;
    tab[2] = 28'h0021181;
    tab[3] = 28'h0020209;
    tab[4] = 28'h8001826;
    tab[5] = 28'h80010a1;
    tick(2);
    hresetn <= 1'b1;
    t_cfg;
    t_ov;
    t_flags;
    t_mirror;
    stop_test;
  end
endmodule // sfm_flag_mask_test
